// ---- logic/tch_tool_change.sv ----
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "tch_consts.svh"

module tch_tool_change (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // PLC side
    output tch_pkg::tch_cmd_t plc_cmd,
    input wire tch_pkg::tch_marks_t plc_marks,
    // Part program flow
    output logic program_stall
);
    import tch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // 0 zero, 1 slot, 2 ground, 3 illegal
    function automatic logic [1:0] pos_class(input logic signed [15:0] p);
        if (p == `TCH_POS_NONE)
            pos_class = 2'h0;
        else if (p == `TCH_POS_GROUND)
            pos_class = 2'h2;
        else if (p > `TCH_POS_NONE)
            pos_class = 2'h1;
        else
            pos_class = 2'h3;
    endfunction

    function automatic logic [4:0] first_mark(input logic [3:0] c);
        case (c)
            4'h1, 4'ha: first_mark = `TCH_MK_M2S;
            4'h2, 4'h5, 4'h6, 4'hc, 4'he: first_mark = `TCH_MK_S2M;
            4'h3, 4'h9: first_mark = `TCH_MK_G2S;
            4'h4, 4'h7, 4'h8: first_mark = `TCH_MK_S2G;
            4'hb, 4'hd: first_mark = `TCH_MK_ROT;
            default: first_mark = `TCH_MK_NONE;
        endcase
    endfunction

    function automatic logic [4:0] second_mark(input logic [3:0] c);
        case (c)
            4'h5, 4'h7, 4'hc, 4'he: second_mark = `TCH_MK_M2S;
            4'h6, 4'h8: second_mark = `TCH_MK_G2S;
            4'h9: second_mark = `TCH_MK_S2M;
            4'ha: second_mark = `TCH_MK_S2G;
            4'hd: second_mark = `TCH_MK_ROT;
            default: second_mark = `TCH_MK_NONE;
        endcase
    endfunction

    // Position classes each exchange code expects, {pickup, dropoff}
    function automatic logic [3:0] need_class(input logic [3:0] c);
        case (c)
            4'h1: need_class = 4'h4;
            4'h2: need_class = 4'h1;
            4'h5, 4'hc, 4'he: need_class = 4'h5;
            4'h6, 4'h9: need_class = 4'h9;
            4'h7, 4'ha: need_class = 4'h6;
            default: need_class = 4'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    logic dph_wr_q;
    logic [7:0] dph_addr_q;
    logic [31:0] hrdata_q;
    logic [3:0] cfg_q;
    logic [3:0] oper_q;
    logic signed [15:0] pick_q;
    logic signed [15:0] drop_q;
    logic [15:0] magsel_q;
    logic [15:0] tool_q;
    logic done_q;
    logic err_q;
    tch_state_t state_q;
    tch_state_t state_d;
    tch_cmd_t cmd_q;
    tch_cmd_t cmd_d;
    logic stall_q;
    logic stall_d;
    logic [4:0] marks_prev_q;

    wire aph_go = hsel && hready && htrans[1];
    wire aph_wr = aph_go && hwrite && (hsize == 3'h2);
    wire wr_ctrl = dph_wr_q && (dph_addr_q == `TCH_OFF_CTRL);
    wire wr_cfg = dph_wr_q && (dph_addr_q == `TCH_OFF_CFG);
    wire wr_oper = dph_wr_q && (dph_addr_q == `TCH_OFF_OPER);
    wire wr_pos = dph_wr_q && (dph_addr_q == `TCH_OFF_POS);
    wire wr_magsel = dph_wr_q && (dph_addr_q == `TCH_OFF_MAGSEL);
    wire wr_tool = dph_wr_q && (dph_addr_q == `TCH_OFF_TOOL);
    wire wr_status = dph_wr_q && (dph_addr_q == `TCH_OFF_STATUS);

    wire busy = (state_q != TCH_ST_IDLE);
    wire [31:0] status_v = {20'h0, cmd_q.code, 2'h0, state_q, err_q, done_q, stall_q, busy};
    logic [31:0] rd_mux;
    always_comb
    begin
        case (haddr[7:0])
            `TCH_OFF_CFG: rd_mux = {28'h0, cfg_q};
            `TCH_OFF_OPER: rd_mux = {28'h0, oper_q};
            `TCH_OFF_POS: rd_mux = {drop_q, pick_q};
            `TCH_OFF_MAGSEL: rd_mux = {16'h0, magsel_q};
            `TCH_OFF_TOOL: rd_mux = {16'h0, tool_q};
            `TCH_OFF_STATUS: rd_mux = status_v;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_wr_q <= 1'b0;
            dph_addr_q <= 8'h00;
            hrdata_q <= 32'h0;
        end
        else if (hready)
        begin
            dph_wr_q <= aph_wr;
            dph_addr_q <= haddr[7:0];
            hrdata_q <= (aph_go && !hwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    assign hrdata = hrdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_q <= `TCH_CFG_RST;
            oper_q <= `TCH_OP_NONE;
            pick_q <= `TCH_POS_NONE;
            drop_q <= `TCH_POS_NONE;
            magsel_q <= 16'h0;
            tool_q <= 16'h0;
        end
        else
        begin
            if (wr_cfg)
                cfg_q <= hwdata[3:0];
            if (wr_oper)
                oper_q <= hwdata[3:0];
            if (wr_pos)
            begin
                pick_q <= hwdata[15:0];
                drop_q <= hwdata[31:16];
            end
            if (wr_magsel)
                magsel_q <= hwdata[15:0];
            if (wr_tool)
                tool_q <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request checks

    wire random = cfg_q[`TCH_CFG_RANDOM];
    wire special = cfg_q[`TCH_CFG_SPECIAL];
    wire machining = cfg_q[`TCH_CFG_MACHINING];
    wire dual = cfg_q[`TCH_CFG_DUAL] && random;
    wire sel_req = wr_ctrl && hwdata[`TCH_CTRL_SELECT];
    wire chg_req = wr_ctrl && hwdata[`TCH_CTRL_CHANGE] && !sel_req;
    wire [1:0] pick_cls = pos_class(pick_q);
    wire [1:0] drop_cls = pos_class(drop_q);
    wire [3:0] cls_ok = need_class(oper_q);
    wire pos_ok = ({pick_cls, drop_cls} == cls_ok);
    wire exch_code = (oper_q <= `TCH_OP_MAX) && (oper_q != `TCH_OP_ORIENT)
        && (oper_q != `TCH_OP_DUAL_ORIENT);
    wire spec_ok = (oper_q != `TCH_OP_SPECIAL) || (random && special);
    wire mag_ok = (oper_q != `TCH_OP_OTHER_MAG)
        || (magsel_q[15:8] != magsel_q[7:0]);
    wire sel_acc = sel_req && !busy;
    wire chg_acc = chg_req && !busy && !machining && exch_code && pos_ok
        && spec_ok && mag_ok;
    wire refused = (sel_req && !sel_acc) || (chg_req && !chg_acc);

    ////////////////////////////////////////////////////////////////////////////////
    // Operation engine

    wire [4:0] marks_v = plc_marks;
    wire [4:0] rise = marks_v & ~marks_prev_q;
    wire [4:0] exp1 = first_mark(cmd_q.code);
    wire [4:0] exp2 = second_mark(cmd_q.code);
    wire hit1 = |(rise & exp1);
    wire hit2 = |(rise & exp2);
    logic fin;

    always_comb
    begin
        state_d = state_q;
        cmd_d = cmd_q;
        stall_d = stall_q;
        fin = 1'b0;
        case (state_q)
            TCH_ST_IDLE:
            begin
                if (sel_acc)
                begin
                    // Preselect: program keeps running
                    cmd_d.valid = 1'b1;
                    cmd_d.code = dual ? `TCH_OP_DUAL_ORIENT : `TCH_OP_ORIENT;
                    cmd_d.pickup = random ? tool_q : `TCH_POS_NONE;
                    cmd_d.dropoff = `TCH_POS_NONE;
                    cmd_d.magsel = dual ? magsel_q : 16'h0;
                    state_d = TCH_ST_FIRST;
                end
                else if (chg_acc && (oper_q == `TCH_OP_NONE))
                    fin = 1'b1;
                else if (chg_acc)
                begin
                    cmd_d.valid = 1'b1;
                    cmd_d.code = oper_q;
                    cmd_d.pickup = pick_q;
                    cmd_d.dropoff = drop_q;
                    cmd_d.magsel = magsel_q;
                    stall_d = 1'b1;
                    state_d = TCH_ST_FIRST;
                end
            end
            TCH_ST_FIRST:
            begin
                // Single-step codes end here
                if (hit1 && (exp2 == `TCH_MK_NONE))
                    fin = 1'b1;
                else if (hit1)
                    state_d = TCH_ST_SECOND;
            end
            TCH_ST_SECOND:
            begin
                if (hit2)
                    fin = 1'b1;
            end
            default: state_d = TCH_ST_IDLE;
        endcase
        if (fin)
        begin
            state_d = TCH_ST_IDLE;
            cmd_d.valid = 1'b0;
            stall_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= TCH_ST_IDLE;
            cmd_q <= '0;
            stall_q <= 1'b0;
            marks_prev_q <= 5'h00;
        end
        else
        begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            stall_q <= stall_d;
            marks_prev_q <= marks_v;
        end
    end

    // Sticky flags: hardware set wins over a software write-one clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            done_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            done_q <= fin || (done_q && !(wr_status && hwdata[`TCH_ST_DONE]));
            err_q <= refused || (err_q && !(wr_status && hwdata[`TCH_ST_ERROR]));
        end
    end

    assign plc_cmd = cmd_q;
    assign program_stall = stall_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_select_preselect: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_acc |=> plc_cmd.valid && (plc_cmd.code == `TCH_OP_ORIENT
            || plc_cmd.code == `TCH_OP_DUAL_ORIENT))
        else $error("select did not issue orientation command");

    a_select_no_stall: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_acc |=> !program_stall [*2])
        else $error("tool select stalled the program");

    a_change_issue: assert property (@(posedge hclk) disable iff (!hresetn)
        chg_acc && (oper_q != `TCH_OP_NONE) |=> plc_cmd.valid
            && (plc_cmd.code == $past(oper_q)) && program_stall)
        else $error("change command not issued");

    a_stall_until_done: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(program_stall) |-> !plc_cmd.valid && $past(fin))
        else $error("stall released before exchange completed");

    a_code_range: assert property (@(posedge hclk) disable iff (!hresetn)
        plc_cmd.valid |-> (plc_cmd.code != `TCH_OP_NONE) && (plc_cmd.code <= `TCH_OP_MAX))
        else $error("command code out of range");

    a_ground_value: assert property (@(posedge hclk) disable iff (!hresetn)
        program_stall && (plc_cmd.pickup < 0) |-> plc_cmd.pickup == `TCH_POS_GROUND)
        else $error("negative position other than ground");

    a_special_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        chg_acc && (oper_q == `TCH_OP_SPECIAL) |-> random && special)
        else $error("code 12 issued outside random special case");

    a_nonrandom_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_acc && !random |=> plc_cmd.code == `TCH_OP_ORIENT
            && plc_cmd.pickup == 16'sh0 && plc_cmd.dropoff == 16'sh0)
        else $error("non-random select not code 11 with zero positions");

    a_no_machining: assert property (@(posedge hclk) disable iff (!hresetn)
        machining |-> !chg_acc)
        else $error("exchange started while machining");

    a_order_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == TCH_ST_FIRST) && !hit1 |=> $stable(cmd_q.code) && busy)
        else $error("out-of-order mark advanced the operation");

    a_two_step_end: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == TCH_ST_SECOND) && hit2 |=> !busy ##1 done_q || !busy)
        else $error("second mark did not end the operation");

endmodule // tch_tool_change

// ---- logic/tch_consts.svh ----
`ifndef TCH_CONSTS_SVH
`define TCH_CONSTS_SVH

// Register byte offsets
`define TCH_OFF_CTRL 8'h00
`define TCH_OFF_CFG 8'h04
`define TCH_OFF_OPER 8'h08
`define TCH_OFF_POS 8'h0c
`define TCH_OFF_MAGSEL 8'h10
`define TCH_OFF_TOOL 8'h14
`define TCH_OFF_STATUS 8'h18

// Control bits (write-only strobes)
`define TCH_CTRL_SELECT 0
`define TCH_CTRL_CHANGE 1

// Configuration bits
`define TCH_CFG_RANDOM 0
`define TCH_CFG_SPECIAL 1
`define TCH_CFG_MACHINING 2
`define TCH_CFG_DUAL 3
`define TCH_CFG_RST 4'h0

// Status bits and fields
`define TCH_ST_BUSY 0
`define TCH_ST_STALL 1
`define TCH_ST_DONE 2
`define TCH_ST_ERROR 3
`define TCH_ST_STEP_LSB 4
`define TCH_ST_CODE_LSB 8

// Field splits
`define TCH_POS_DROP_LSB 16
`define TCH_MAG_HALF 8

// Operation codes
`define TCH_OP_NONE 4'h0
`define TCH_OP_ORIENT 4'hb
`define TCH_OP_SPECIAL 4'hc
`define TCH_OP_DUAL_ORIENT 4'hd
`define TCH_OP_OTHER_MAG 4'he
`define TCH_OP_MAX 4'he

// Position values
`define TCH_POS_NONE 16'sh0000
`define TCH_POS_GROUND 16'shfffc

// Completion mark one-hot codes, bit order of tch_marks_t
`define TCH_MK_NONE 5'h00
`define TCH_MK_M2S 5'h01
`define TCH_MK_S2M 5'h02
`define TCH_MK_G2S 5'h04
`define TCH_MK_S2G 5'h08
`define TCH_MK_ROT 5'h10

`endif

// ---- logic/tch_pkg.sv ----
package tch_pkg;

    // Engine states, Gray along idle-first-second
    typedef enum logic [1:0] {
        TCH_ST_IDLE = 2'h0,
        TCH_ST_FIRST = 2'h1,
        TCH_ST_SECOND = 2'h3
    } tch_state_t;

    // Command presented to the PLC
    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic signed [15:0] pickup;
        logic signed [15:0] dropoff;
        logic [15:0] magsel;
    } tch_cmd_t;

    // Completion marks raised by the PLC, magazine_to_spindle_done is bit 0
    typedef struct packed {
        logic magazine_oriented_done;
        logic spindle_to_ground_done;
        logic ground_to_spindle_done;
        logic spindle_to_magazine_done;
        logic magazine_to_spindle_done;
    } tch_marks_t;

endpackage

// ---- verification/tch_plc_model.sv ----
`timescale 1ns/1ps
`include "tch_consts.svh"

module tch_plc_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Command from the tool manager, marks back to it
    input wire tch_pkg::tch_cmd_t plc_cmd,
    output tch_pkg::tch_marks_t plc_marks,
    // Scenario control: extra cycles per step, out-of-order mark first
    input wire logic [3:0] dly,
    input wire logic wrong
);
    import tch_pkg::*;

    logic [4:0] m1;
    logic [4:0] m2;

    function automatic logic [4:0] first_mk(input logic [3:0] c);
        case (c)
            4'h1, 4'ha: return `TCH_MK_M2S;
            4'h2, 4'h5, 4'h6, 4'hc, 4'he: return `TCH_MK_S2M;
            4'h3, 4'h9: return `TCH_MK_G2S;
            4'h4, 4'h7, 4'h8: return `TCH_MK_S2G;
            4'hb, 4'hd: return `TCH_MK_ROT;
            default: return `TCH_MK_NONE;
        endcase
    endfunction

    function automatic logic [4:0] second_mk(input logic [3:0] c);
        case (c)
            4'h5, 4'h7, 4'hc, 4'he: return `TCH_MK_M2S;
            4'h6, 4'h8: return `TCH_MK_G2S;
            4'h9: return `TCH_MK_S2M;
            4'ha: return `TCH_MK_S2G;
            4'hd: return `TCH_MK_ROT;
            default: return `TCH_MK_NONE;
        endcase
    endfunction

    // One mark for one cycle, then a low cycle so the next one is a fresh edge
    task automatic pulse(input logic [4:0] m);
        repeat (dly) @(posedge hclk);
        plc_marks <= tch_marks_t'(m);
        @(posedge hclk);
        plc_marks <= tch_marks_t'(`TCH_MK_NONE);
        @(posedge hclk);
    endtask

    initial
    begin
        plc_marks = tch_marks_t'(`TCH_MK_NONE);
        forever
        begin
            @(posedge hclk);
            if (hresetn === 1'b1 && plc_cmd.valid === 1'b1)
            begin
                m1 = first_mk(plc_cmd.code);
                m2 = second_mk(plc_cmd.code);
                if (wrong)
                    pulse(m2);
                pulse(m1);
                if (m2 != `TCH_MK_NONE)
                    pulse(m2);
                while (plc_cmd.valid === 1'b1) @(posedge hclk);
            end
        end
    end
endmodule // tch_plc_model

// ---- verification/tb_tch_tool_change.sv ----
`timescale 1ns/1ps
`include "tch_consts.svh"

module tb_tch_tool_change;
    import tch_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    tch_cmd_t plc_cmd;
    tch_marks_t plc_marks;
    logic program_stall;
    logic [3:0] dly = 4'h0;
    logic wrong = 1'b0;
    logic exp_stall = 1'b0;
    logic vq = 1'b0;
    tch_cmd_t cap;
    logic [31:0] rd;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int last_mk = 0;
    int fall_cyc = 0;
    int n_rise = 0;
    int n_fall = 0;
    logic [3:0] cd [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha,
        4'hc, 4'he};
    logic [15:0] pk [12] = '{16'h3, 16'h0, 16'h0, 16'h0, 16'h3, 16'hfffc, 16'h3, 16'h0,
        16'hfffc, 16'h3, 16'h3, 16'h3};
    logic [15:0] dp [12] = '{16'h0, 16'h5, 16'h0, 16'h0, 16'h5, 16'h5, 16'hfffc, 16'h0,
        16'h5, 16'hfffc, 16'h5, 16'h5};

    always #2.5 hclk = ~hclk;

    tch_tool_change u_tch_tool_change (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .plc_cmd(plc_cmd), .plc_marks(plc_marks), .program_stall(program_stall));

    tch_plc_model u_tch_plc_model (.hclk(hclk), .hresetn(hresetn), .plc_cmd(plc_cmd),
        .plc_marks(plc_marks), .dly(dly), .wrong(wrong));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic bound(input int n);
        if (n >= 200)
        begin
            error_cnt++;
            $display("CHECK FAILED wait expected answer seen timeout");
            final_report();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 200);
        bound(n);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 200);
        bound(n);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic setup(input logic [3:0] cfg, input logic [3:0] code, input logic [31:0] pos);
        wr(`TCH_OFF_CFG, {28'h0, cfg});
        wr(`TCH_OFF_OPER, {28'h0, code});
        wr(`TCH_OFF_POS, pos);
    endtask

    // Request, wait for completion, compare command, release timing and status
    task automatic op(input logic [31:0] ctrl, input logic [3:0] c, input logic [15:0] p,
        input logic [15:0] d, input logic [15:0] ms, input logic poke);
        int f0;
        int n;
        f0 = n_fall;
        exp_stall = ctrl[1] & ~ctrl[0];
        wr(`TCH_OFF_CTRL, ctrl);
        if (poke)
            wr(`TCH_OFF_CTRL, 32'h1);
        n = 0;
        while (n_fall == f0 && n < 200)
        begin
            @(posedge hclk);
            n++;
        end
        bound(n);
        chk("code", {28'h0, c}, {28'h0, cap.code});
        chk("pickup", {16'h0, p}, {16'h0, cap.pickup});
        chk("dropoff", {16'h0, d}, {16'h0, cap.dropoff});
        if (ctrl[0] || c == `TCH_OP_OTHER_MAG)
            chk("magsel", {16'h0, ms}, {16'h0, cap.magsel});
        chk("release_cycle", last_mk + 1, fall_cyc);
        ahb(1'b0, `TCH_OFF_STATUS, 32'h0);
        chk("status", {28'h0, poke, 3'h4}, rd & 32'h3f);
        wr(`TCH_OFF_STATUS, 32'hc);
    endtask

    task automatic no_cmd(input logic [3:0] cfg, input logic [3:0] code, input logic [31:0] pos,
        input logic [3:0] st);
        int r0;
        r0 = n_rise;
        setup(cfg, code, pos);
        wr(`TCH_OFF_CTRL, 32'h2);
        repeat (3) @(posedge hclk);
        chk("commands", r0, n_rise);
        ahb(1'b0, `TCH_OFF_STATUS, 32'h0);
        chk("status", {28'h0, st}, rd & 32'h3f);
        wr(`TCH_OFF_STATUS, 32'hc);
    endtask

    ////////////////////////////////////////////////////////////////
    // Command capture, release timing and stall tracking
    always @(posedge hclk)
    begin
        cyc++;
        if (plc_marks !== tch_marks_t'(`TCH_MK_NONE))
            last_mk = cyc;
        if (plc_cmd.valid === 1'b1 && !vq)
        begin
            cap = plc_cmd;
            n_rise++;
        end
        if (plc_cmd.valid !== 1'b1 && vq)
        begin
            fall_cyc = cyc;
            n_fall++;
        end
        vq = (plc_cmd.valid === 1'b1);
        // Outputs are unknown until the first reset edge has landed
        if (hresetn === 1'b1)
            chk("program_stall", {31'h0, plc_cmd.valid & exp_stall},
                {31'h0, program_stall});
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `TCH_OFF_CFG, 32'h0);
        chk("cfg_reset", 32'h0, rd);
        ahb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h0, rd);
        wr(`TCH_OFF_MAGSEL, 32'h0201);
        wr(`TCH_OFF_TOOL, 32'h7);
        ahb(1'b0, `TCH_OFF_MAGSEL, 32'h0);
        chk("magsel_rw", 32'h0201, rd);
        $display("test registers done");
        setup(4'h0, 4'h0, 32'h0);
        op(32'h1, `TCH_OP_ORIENT, 16'h0, 16'h0, 16'h0, 1'b0);
        setup(4'h1, 4'h0, 32'h0);
        op(32'h3, `TCH_OP_ORIENT, 16'h7, 16'h0, 16'h0, 1'b0);
        setup(4'h9, 4'h0, 32'h0);
        op(32'h1, `TCH_OP_DUAL_ORIENT, 16'h7, 16'h0, 16'h0201, 1'b0);
        $display("test select done");
        for (int i = 0; i < 12; i++)
        begin
            setup(4'h3, cd[i], {dp[i], pk[i]});
            op(32'h2, cd[i], pk[i], dp[i], 16'h0201, 1'b0);
        end
        $display("test change codes done");
        dly <= 4'h5;
        wrong <= 1'b1;
        setup(4'h3, 4'h5, 32'h00050003);
        op(32'h2, 4'h5, 16'h3, 16'h5, 16'h0, 1'b0);
        wrong <= 1'b0;
        setup(4'h3, 4'h1, 32'h3);
        op(32'h2, 4'h1, 16'h3, 16'h0, 16'h0, 1'b1);
        dly <= 4'h0;
        $display("test slow plc done");
        no_cmd(4'h7, 4'h1, 32'h3, 4'h8);
        no_cmd(4'h2, 4'hc, 32'h00050003, 4'h8);
        no_cmd(4'h3, 4'h5, 32'hfffc0003, 4'h8);
        no_cmd(4'h3, 4'hd, 32'h00050003, 4'h8);
        no_cmd(4'h3, 4'hf, 32'h00050003, 4'h8);
        no_cmd(4'h3, 4'h0, 32'h0, 4'h4);
        $display("test refusals done");
        final_report();
    end
endmodule // tb_tch_tool_change
